// ==== shared/ebu_pkg.sv ====
// Shared constants and types for the external bus unit
package ebu_pkg;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'h1,
    ST_ACTIVE = 4'h2,
    ST_NEXT   = 4'h4,
    ST_HALT   = 4'h8
  } ebu_state_t;

  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int OPER_W = 32;
  localparam int BYTE_W = 8;

  // Port size acknowledge pair, active low, {bit1, bit0}
  localparam logic [1:0] ACK_WAIT = 2'h3;
  localparam logic [1:0] ACK_8    = 2'h2;
  localparam logic [1:0] ACK_16   = 2'h1;
  localparam logic [1:0] ACK_RSVD = 2'h0;

  // Transfer size encodings
  localparam logic [1:0] TSIZE_LONG  = 2'h0;
  localparam logic [1:0] TSIZE_BYTE  = 2'h1;
  localparam logic [1:0] TSIZE_WORD  = 2'h2;
  localparam logic [1:0] TSIZE_THREE = 2'h3;

  // Bytes remaining; low two bits equal the transfer size code
  localparam logic [2:0] REM_NONE  = 3'h0;
  localparam logic [2:0] REM_BYTE  = 3'h1;
  localparam logic [2:0] REM_WORD  = 3'h2;
  localparam logic [2:0] REM_THREE = 3'h3;
  localparam logic [2:0] REM_LONG  = 3'h4;

  localparam logic [2:0] STEP_ONE = 3'h1;
  localparam logic [2:0] STEP_TWO = 3'h2;

  localparam logic [2:0] SPACE_CPU = 3'h7;

  // Default bus monitor timeout, in system clock cycles
  localparam int BUS_TIMEOUT_CYCLES = 64;

endpackage : ebu_pkg

// ==== hdl/bus_timeout_monitor.sv ====
// Bus cycle timeout monitor
`timescale 1ns/10ps
module bus_timeout_monitor
  import ebu_pkg::*;
#(
  parameter int LIMIT = BUS_TIMEOUT_CYCLES
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_run,
  output logic      o_expire
);

  localparam int             CW   = $clog2(LIMIT + 1);
  localparam logic [CW-1:0]  LAST = CW'(LIMIT - 1);
  localparam logic [CW-1:0]  ONE  = CW'(1);

  logic [CW-1:0] count_q;
  logic [CW-1:0] count_d;

  // Restarts on every bus cycle so each cycle gets the full window
  always_comb begin
    count_d = '0;
    if (i_run) begin
      count_d = (count_q == LAST) ? count_q : count_q + ONE;
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_expire = i_run && (count_q == LAST);

  AST_TMO_FIRE: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    o_expire |-> $past(i_run) || (LIMIT == 1))
    else $error("Timeout fired without a running cycle");

  AST_TMO_CLEAR: assert property (@(posedge i_clk) disable iff (!i_reset_n)
    !i_run |=> (count_q == '0))
    else $error("Timeout count not cleared between cycles");

endmodule : bus_timeout_monitor

// ==== hdl/port_lane_router.sv ====
// Acknowledge decode and read byte lane selection
`timescale 1ns/10ps
module port_lane_router
  import ebu_pkg::*;
(
  input  wire logic [1:0]        i_ack_n,
  input  wire logic              i_byte_offset_line,
  input  wire logic [2:0]        i_rem,
  input  wire logic [DATA_W-1:0] i_data,
  output logic                   o_ack_ok,
  output logic [2:0]             o_step,
  output logic [BYTE_W-1:0]      o_rbyte
);

  logic port8;

  // Reserved code is treated like wait states
  assign o_ack_ok = (i_ack_n == ACK_8) || (i_ack_n == ACK_16);
  assign port8    = (i_ack_n == ACK_8);

  // One aligned word at most per cycle
  assign o_step = (port8 || i_byte_offset_line || (i_rem == REM_BYTE)) ?
                  STEP_ONE : STEP_TWO;

  // 8-bit ports and even bytes sit on the upper lane
  assign o_rbyte = (!port8 && i_byte_offset_line) ? i_data[BYTE_W-1:0]
                                       : i_data[DATA_W-1:BYTE_W];

endmodule : port_lane_router

// ==== hdl/external_bus_unit.sv ====
// External bus unit with dynamic sizing, halt, fault and autovector
`timescale 1ns/10ps
module external_bus_unit
  import ebu_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = BUS_TIMEOUT_CYCLES
) (
  input  wire logic              I_MCLK,
  input  wire logic              I_RESET_N,
  input  wire logic              I_REQ,
  input  wire logic              I_READ,
  input  wire logic [1:0]        I_SIZE,
  input  wire logic [ADDR_W-1:0] I_ADDR,
  input  wire logic [2:0]        I_SPACE_CODE,
  input  wire logic              I_IACK,
  input  wire logic [OPER_W-1:0] I_WDATA,
  input  wire logic              I_EXT_MASTER,
  input  wire logic              I_MONITOR_EN,
  input  wire logic [DATA_W-1:0] I_DATA,
  input  wire logic [1:0]        I_PORT_SIZE_ACK_N,
  input  wire logic              I_BUS_FAULT_IN_N,
  input  wire logic              I_HALT_N,
  input  wire logic              I_AUTO_VECTOR_ACK_N,
  output logic                   O_BUSY,
  output logic                   O_DONE,
  output logic                   O_FAULT,
  output logic                   O_MISALIGN,
  output logic                   O_AUTOVEC,
  output logic [OPER_W-1:0]      O_RDATA,
  output logic                   O_HALTED,
  output logic [ADDR_W-1:0]      O_ADDR,
  output logic [2:0]             O_SPACE_CODE,
  output logic [1:0]             O_TRANSFER_SIZE,
  output logic                   O_READ,
  output logic                   O_BUS_OE,
  output logic                   O_AS_N,
  output logic                   O_DS_N,
  output logic [DATA_W-1:0]      O_DATA,
  output logic                   O_DATA_OE
);

  ebu_state_t          state_q,   state_d;
  logic [ADDR_W-1:0]   addr_q,    addr_d;
  logic [2:0]          rem_q,     rem_d;
  logic [OPER_W-1:0]   wbuf_q,    wbuf_d;
  logic [OPER_W-1:0]   acc_q,     acc_d;
  logic                read_q,    read_d;
  logic [2:0]          space_q,   space_d;
  logic                iack_q,    iack_d;
  logic                busy_q,    busy_d;
  logic                done_q,    done_d;
  logic                fault_q,   fault_d;
  logic                mis_q,     mis_d;
  logic                auto_vector_ack_q,    auto_vector_ack_d;
  logic [OPER_W-1:0]   rdata_q,   rdata_d;
  logic                halted_q,  halted_d;
  logic                bus_oe_q,  bus_oe_d;
  logic                as_n_q,    as_n_d;
  logic                ds_n_q,    ds_n_d;
  logic [DATA_W-1:0]   data_q,    data_d;
  logic                data_oe_q, data_oe_d;
  // Pin copies freeze through halt while the sequencer already advanced
  logic [ADDR_W-1:0]   pin_addr_q, pin_addr_d;
  logic [1:0]          pin_size_q, pin_size_d;

  logic                ack_ok;
  logic [2:0]          step;
  logic [BYTE_W-1:0]   rbyte;
  logic                tmo_run;
  logic                tmo_expire;
  logic                fault_in;
  logic                auto_vector_ack_hit;
  logic                start_ok;
  logic                misaligned;
  logic [2:0]          req_rem;
  logic [2:0]          rem_left;

  port_lane_router u_router (
    .i_ack_n  (I_PORT_SIZE_ACK_N),
    .i_byte_offset_line  (addr_q[0]),
    .i_rem    (rem_q),
    .i_data   (I_DATA),
    .o_ack_ok (ack_ok),
    .o_step   (step),
    .o_rbyte  (rbyte)
  );

  // Monitor is blind to transfers started by an outside master
  assign tmo_run = (state_q == ST_ACTIVE) && I_MONITOR_EN
                   && !I_EXT_MASTER;

  bus_timeout_monitor #(
    .LIMIT (TIMEOUT_CYCLES)
  ) u_monitor (
    .i_clk     (I_MCLK),
    .i_reset_n (I_RESET_N),
    .i_run     (tmo_run),
    .o_expire  (tmo_expire)
  );

  assign fault_in = !I_BUS_FAULT_IN_N || tmo_expire;
  assign auto_vector_ack_hit = iack_q && !I_EXT_MASTER
                    && !I_AUTO_VECTOR_ACK_N;
  assign req_rem  = (I_SIZE == TSIZE_LONG) ? REM_LONG : {1'b0, I_SIZE};
  assign misaligned = I_ADDR[0] && (I_SIZE != TSIZE_BYTE);
  // A new external cycle waits out halt and foreign mastership
  assign start_ok = (state_q == ST_IDLE) && I_REQ && I_HALT_N
                    && !I_EXT_MASTER;
  assign rem_left = rem_q - step;

  always_comb begin
    state_d  = state_q;
    addr_d   = addr_q;
    rem_d    = rem_q;
    wbuf_d   = wbuf_q;
    acc_d    = acc_q;
    read_d   = read_q;
    space_d  = space_q;
    iack_d   = iack_q;
    rdata_d  = rdata_q;
    done_d   = 1'b0;
    fault_d  = 1'b0;
    mis_d    = 1'b0;
    auto_vector_ack_d   = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (start_ok && misaligned) begin
          done_d  = 1'b1;
          fault_d = 1'b1;
          mis_d   = 1'b1;
        end else if (start_ok) begin
          state_d = ST_ACTIVE;
          addr_d  = I_ADDR;
          rem_d   = req_rem;
          read_d  = I_READ;
          space_d = I_SPACE_CODE;
          iack_d  = I_IACK && (I_SPACE_CODE == SPACE_CPU);
          acc_d   = '0;
          // Left justify so the top byte always leaves first
          case (I_SIZE)
            TSIZE_BYTE: wbuf_d = {I_WDATA[7:0], 24'h000000};
            TSIZE_WORD: wbuf_d = {I_WDATA[15:0], 16'h0000};
            default:    wbuf_d = I_WDATA;
          endcase
        end
      end
      ST_ACTIVE: begin
        if (auto_vector_ack_hit) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
          auto_vector_ack_d  = 1'b1;
          rdata_d = '0;
        end else if (fault_in && !I_HALT_N) begin
          state_d = ST_HALT;
        end else if (fault_in) begin
          state_d = ST_IDLE;
          done_d  = 1'b1;
          fault_d = 1'b1;
        end else if (ack_ok) begin
          rem_d  = rem_left;
          addr_d = addr_q + ADDR_W'(step);
          if (step == STEP_TWO) begin
            wbuf_d = {wbuf_q[15:0], 16'h0000};
          end else begin
            wbuf_d = {wbuf_q[23:0], 8'h00};
          end
          if (read_q && step == STEP_TWO) begin
            acc_d = {acc_q[15:0], I_DATA};
          end else if (read_q) begin
            acc_d = {acc_q[23:0], rbyte};
          end
          if (rem_left == REM_NONE) begin
            state_d = ST_IDLE;
            done_d  = 1'b1;
            rdata_d = read_q ? acc_d : rdata_q;
          end else if (!I_HALT_N) begin
            state_d = ST_HALT;
          end else begin
            state_d = ST_NEXT;
          end
        end
      end
      ST_NEXT: begin
        state_d = ST_ACTIVE;
      end
      ST_HALT: begin
        // Resumes the pending portion, which is a retry only when halt came with a fault
        if (I_HALT_N) begin
          state_d = ST_ACTIVE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    busy_d    = (state_d != ST_IDLE);
    halted_d  = (state_d == ST_HALT)
                || (state_d == ST_IDLE && !I_HALT_N);
    bus_oe_d  = !I_EXT_MASTER;
    as_n_d    = (state_d != ST_ACTIVE);
    // Write data strobe trails the address strobe by one clock
    ds_n_d    = !((state_d == ST_ACTIVE)
                  && (read_d || state_q == ST_ACTIVE));
    data_oe_d = !read_d && ((state_d == ST_ACTIVE)
                            || (state_d == ST_NEXT));
    pin_addr_d = (state_d == ST_HALT) ? pin_addr_q : addr_d;
    pin_size_d = (state_d == ST_HALT) ? pin_size_q : rem_d[1:0];
    if (addr_d[0] || rem_d == REM_BYTE) begin
      data_d = {wbuf_d[31:24], wbuf_d[31:24]};
    end else begin
      data_d = wbuf_d[31:16];
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_q   <= ST_IDLE;
      addr_q    <= '0;
      rem_q     <= REM_NONE;
      wbuf_q    <= '0;
      acc_q     <= '0;
      read_q    <= 1'b1;
      space_q   <= '0;
      iack_q    <= 1'b0;
      busy_q    <= 1'b0;
      done_q    <= 1'b0;
      fault_q   <= 1'b0;
      mis_q     <= 1'b0;
      auto_vector_ack_q    <= 1'b0;
      rdata_q   <= '0;
      halted_q  <= 1'b0;
      bus_oe_q  <= 1'b0;
      as_n_q    <= 1'b1;
      ds_n_q    <= 1'b1;
      data_q    <= '0;
      data_oe_q <= 1'b0;
      pin_addr_q <= '0;
      pin_size_q <= TSIZE_LONG;
    end else begin
      state_q   <= state_d;
      addr_q    <= addr_d;
      rem_q     <= rem_d;
      wbuf_q    <= wbuf_d;
      acc_q     <= acc_d;
      read_q    <= read_d;
      space_q   <= space_d;
      iack_q    <= iack_d;
      busy_q    <= busy_d;
      done_q    <= done_d;
      fault_q   <= fault_d;
      mis_q     <= mis_d;
      auto_vector_ack_q    <= auto_vector_ack_d;
      rdata_q   <= rdata_d;
      halted_q  <= halted_d;
      bus_oe_q  <= bus_oe_d;
      as_n_q    <= as_n_d;
      ds_n_q    <= ds_n_d;
      data_q    <= data_d;
      data_oe_q <= data_oe_d;
      pin_addr_q <= pin_addr_d;
      pin_size_q <= pin_size_d;
    end
  end

  assign O_BUSY          = busy_q;
  assign O_DONE          = done_q;
  assign O_FAULT         = fault_q;
  assign O_MISALIGN      = mis_q;
  assign O_AUTOVEC       = auto_vector_ack_q;
  assign O_RDATA         = rdata_q;
  assign O_HALTED        = halted_q;
  assign O_ADDR          = pin_addr_q;
  assign O_SPACE_CODE    = space_q;
  assign O_TRANSFER_SIZE = pin_size_q;
  assign O_READ          = read_q;
  assign O_BUS_OE        = bus_oe_q;
  assign O_AS_N          = as_n_q;
  assign O_DS_N          = ds_n_q;
  assign O_DATA          = data_q;
  assign O_DATA_OE       = data_oe_q;

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RESET_N);

  logic quiet;
  assign quiet = I_BUS_FAULT_IN_N && I_HALT_N && !tmo_expire && !auto_vector_ack_hit;

  sequence s_long16_first;
    (state_q == ST_ACTIVE) && (rem_q == REM_LONG)
    && (I_PORT_SIZE_ACK_N == ACK_16) && quiet;
  endsequence

  sequence s_word_follow;
    (state_q == ST_NEXT) ##1 ((state_q == ST_ACTIVE)
    && (rem_q == REM_WORD) && (O_TRANSFER_SIZE == TSIZE_WORD));
  endsequence

  AST_LONG16_CHAIN: assert property (s_long16_first |=> s_word_follow)
    else $error("Long word to 16-bit port did not chain one word");

  AST_WAIT_STATES: assert property ((state_q == ST_ACTIVE) && quiet
    && (I_PORT_SIZE_ACK_N == ACK_WAIT) |=> (state_q == ST_ACTIVE)
    && !O_AS_N)
    else $error("Cycle ended without an acknowledge");

  AST_READ_LATCH: assert property ((state_q == ST_ACTIVE) && read_q
    && quiet && (I_PORT_SIZE_ACK_N == ACK_16) && (rem_q == REM_WORD)
    && !addr_q[0] |=> O_DONE && (O_RDATA[15:0] == $past(I_DATA)))
    else $error("Read word not latched at acknowledge");

  AST_HALT_FLOAT: assert property ((state_q == ST_HALT) |-> !O_DATA_OE
    && O_AS_N && O_DS_N && O_HALTED)
    else $error("Bus not released while halted");

  AST_HALT_HOLD: assert property ((state_q == ST_HALT)
    && ($past(state_q) == ST_HALT) |-> $stable(O_ADDR)
    && $stable(O_TRANSFER_SIZE) && $stable(O_READ))
    else $error("Held outputs changed while halted");

  AST_REDRIVE: assert property ((state_q == ST_HALT) && !I_EXT_MASTER
    |=> O_BUS_OE)
    else $error("Outputs not redriven after bus returned");

  AST_WRITE_DRIVE: assert property (!O_READ && !O_AS_N |-> O_DATA_OE)
    else $error("Write cycle without driven data lines");

  AST_WORD_LANES: assert property ((state_q == ST_ACTIVE) && !O_READ
    && !O_ADDR[0] && (rem_q != REM_BYTE)
    |-> (O_DATA == wbuf_q[31:16]))
    else $error("Word not placed high byte upper");

  AST_MISALIGN: assert property (start_ok && misaligned
    |=> O_FAULT && O_MISALIGN && O_AS_N)
    else $error("Misaligned request not refused");

  AST_AUTO_VECTOR_ACK_EXT: assert property ((state_q == ST_ACTIVE) && I_EXT_MASTER
    |=> !O_AUTOVEC)
    else $error("Autovector honoured under external master");

  AST_AUTO_VECTOR_ACK_ONLY_IACK: assert property ($rose(O_AUTOVEC)
    |-> $past(iack_q))
    else $error("Autovector ended a non acknowledge cycle");

endmodule : external_bus_unit

// ==== tb/ext_port_model.sv ====
// Behavioural model of an external memory port, 8 or 16 bits wide
`timescale 1ns/10ps
module ext_port_model
  import ebu_pkg::*;
(
  input  wire logic              i_clk,
  input  wire logic              i_as_n,
  input  wire logic              i_ds_n,
  input  wire logic              i_read,
  input  wire logic [ADDR_W-1:0] i_addr,
  input  wire logic [1:0]        i_tsize,
  input  wire logic [DATA_W-1:0] i_data,
  input  wire logic              i_wide,
  input  wire logic [3:0]        i_waits,
  input  wire logic              i_fault,
  input  wire logic              i_mute,
  output logic [DATA_W-1:0]      o_data,
  output logic [1:0]             o_ack_n,
  output logic                   o_fault_n
);
  logic [7:0] mem [0:255];
  logic [3:0] cnt_q;
  logic       done_q;
  logic [7:0] a;
  assign a = i_addr[7:0];
  initial begin
    for (int k = 0; k < 256; k++) mem[k] = 8'(k) ^ 8'h5a;
    o_ack_n = ACK_WAIT;
    o_fault_n = 1'b1;
    o_data = 16'h0000;
    cnt_q = 4'h0;
    done_q = 1'b0;
  end
  always @(posedge i_clk) begin
    if (i_as_n) begin
      o_ack_n <= ACK_WAIT;
      o_fault_n <= 1'b1;
      // Released lines must not keep showing the last value
      o_data <= ~o_data;
      cnt_q <= 4'h0;
      done_q <= 1'b0;
    end else if (!i_ds_n && !done_q && !i_mute) begin
      if (cnt_q != i_waits) begin
        cnt_q <= cnt_q + 4'h1;
      end else begin
        done_q <= 1'b1;
        if (i_fault) o_fault_n <= 1'b0;
        else o_ack_n <= i_wide ? ACK_16 : ACK_8;
        if (i_read) begin
          o_data <= i_wide ? {mem[a & 8'hfe], mem[a | 8'h01]}
                           : {mem[a], ~mem[a]};
        end else if (!i_wide) begin
          mem[a] <= i_data[15:8];
        end else if (i_tsize == TSIZE_BYTE) begin
          mem[a] <= a[0] ? i_data[7:0] : i_data[15:8];
        end else begin
          mem[a] <= i_data[15:8];
          mem[a | 8'h01] <= i_data[7:0];
        end
      end
    end
  end
endmodule : ext_port_model

// ==== tb/testbench.sv ====
// Self-checking bench for the external bus unit
`timescale 1ns/10ps
module testbench
  import ebu_pkg::*;
();
  logic              clk, rst_n, req, rd, iack, extm, mon_en, halt_n;
  logic              auto_vector_ack_n, wide, fault, mute, busy, done, flt, mis;
  logic              auto_vector_ack, halted, fault_n, oread, bus_oe, as_n, ds_n;
  logic              doe, r_flt, r_mis, r_av;
  logic              as_d = 1'b1;
  logic [3:0]        waits;
  logic [1:0]        sz, ack_n, tsize;
  logic [2:0]        space, ospace;
  logic [ADDR_W-1:0] addr, oaddr;
  logic [OPER_W-1:0] wdata, rdata, r_data;
  logic [DATA_W-1:0] din, dout;
  logic [26:0]       log_q[$];
  int                miscompares, samples_checked;

  external_bus_unit #(.TIMEOUT_CYCLES(4)) uut (
    .I_MCLK(clk), .I_RESET_N(rst_n), .I_REQ(req), .I_READ(rd),
    .I_SIZE(sz), .I_ADDR(addr), .I_SPACE_CODE(space), .I_IACK(iack),
    .I_WDATA(wdata), .I_EXT_MASTER(extm), .I_MONITOR_EN(mon_en),
    .I_DATA(din), .I_PORT_SIZE_ACK_N(ack_n), .I_BUS_FAULT_IN_N(fault_n),
    .I_HALT_N(halt_n), .I_AUTO_VECTOR_ACK_N(auto_vector_ack_n), .O_BUSY(busy),
    .O_DONE(done), .O_FAULT(flt), .O_MISALIGN(mis), .O_AUTOVEC(auto_vector_ack),
    .O_RDATA(rdata), .O_HALTED(halted), .O_ADDR(oaddr),
    .O_SPACE_CODE(ospace), .O_TRANSFER_SIZE(tsize), .O_READ(oread),
    .O_BUS_OE(bus_oe), .O_AS_N(as_n), .O_DS_N(ds_n), .O_DATA(dout),
    .O_DATA_OE(doe));

  ext_port_model u_mem (
    .i_clk(clk), .i_as_n(as_n), .i_ds_n(ds_n), .i_read(oread),
    .i_addr(oaddr), .i_tsize(tsize), .i_data(dout), .i_wide(wide),
    .i_waits(waits), .i_fault(fault), .i_mute(mute), .o_data(din),
    .o_ack_n(ack_n), .o_fault_n(fault_n));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // One entry per bus cycle, taken where the address strobe falls
  always @(posedge clk) begin
    as_d <= as_n;
    if (as_d === 1'b1 && as_n === 1'b0) log_q.push_back({doe, tsize, oaddr});
  end

  function automatic logic [7:0] mb(input logic [23:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : mb

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic start(input logic r, input logic [1:0] s,
                       input logic [23:0] a, input logic [31:0] w);
    log_q.delete();
    req <= 1'b1;
    rd <= r;
    sz <= s;
    addr <= a;
    wdata <= w;
    @(posedge clk);
    req <= 1'b0;
  endtask : start

  task automatic wait_done();
    int n;
    n = 0;
    while (done !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk("done", 32'h1, 32'(done));
    r_flt = flt;
    r_mis = mis;
    r_av = auto_vector_ack;
    r_data = rdata;
  endtask : wait_done

  task automatic long_read(input logic w, input logic [23:0] a);
    logic [1:0] s8 [4] = '{TSIZE_LONG, TSIZE_THREE, TSIZE_WORD, TSIZE_BYTE};
    wide <= w;
    start(1'b1, TSIZE_LONG, a, 32'h0);
    wait_done();
    chk("rdata", {mb(a), mb(a + 1), mb(a + 2), mb(a + 3)}, r_data);
    chk("cycles", w ? 2 : 4, log_q.size());
    for (int k = 0; k < log_q.size(); k++) begin
      chk("tsize", w ? (k ? TSIZE_WORD : TSIZE_LONG) : s8[k],
          32'(log_q[k][25:24]));
      chk("addr", a + 24'(w ? 2 * k : k), 32'(log_q[k][23:0]));
    end
  endtask : long_read

  task automatic byte_read(input logic w, input logic [23:0] a);
    wide <= w;
    start(1'b1, TSIZE_BYTE, a, 32'h0);
    wait_done();
    chk("rbyte", 32'(mb(a)), 32'(r_data[7:0]));
    chk("tsize", 32'(TSIZE_BYTE), 32'(log_q[0][25:24]));
  endtask : byte_read

  task automatic check_mem(input logic [23:0] a, input logic [31:0] v);
    for (int k = 0; k < 4; k++) begin
      chk("mem", 32'(v[31 - 8 * k -: 8]),
          32'(u_mem.mem[a[7:0] + 8'(k)]));
    end
  endtask : check_mem

  task automatic long_write(input logic w, input logic [23:0] a,
                            input logic [31:0] v);
    wide <= w;
    start(1'b0, TSIZE_LONG, a, v);
    wait_done();
    check_mem(a, v);
    chk("data_oe", 32'h1, 32'(log_q[0][26]));
    chk("cycles", w ? 2 : 4, log_q.size());
  endtask : long_write

  task automatic faults();
    start(1'b1, TSIZE_WORD, 24'h000051, 32'h0);
    wait_done();
    chk("misalign", 32'h3, {r_flt, r_mis});
    chk("cycles", 32'h0, log_q.size());
    fault <= 1'b1;
    start(1'b1, TSIZE_WORD, 24'h000010, 32'h0);
    wait_done();
    chk("fault", 32'h2, {r_flt, r_mis});
    fault <= 1'b0;
    mute <= 1'b1;
    mon_en <= 1'b1;
    start(1'b1, TSIZE_WORD, 24'h000010, 32'h0);
    wait_done();
    chk("timeout", 32'h1, 32'(r_flt));
    mute <= 1'b0;
    mon_en <= 1'b0;
  endtask : faults

  task automatic slow_read();
    // Waits stretch the cycle; autovector must not end a plain read
    waits <= 4'h2;
    auto_vector_ack_n <= 1'b0;
    wide <= 1'b1;
    start(1'b1, TSIZE_WORD, 24'h000010, 32'h0);
    wait_done();
    chk("rdata", {mb(24'h10), mb(24'h11)}, 32'(r_data[15:0]));
    chk("autovec", 32'h0, 32'(r_av));
    waits <= 4'h0;
    auto_vector_ack_n <= 1'b1;
  endtask : slow_read

  task automatic halt_test();
    int n;
    wide <= 1'b1;
    start(1'b0, TSIZE_LONG, 24'h0000a0, 32'hcafe1234);
    halt_n <= 1'b0;
    n = 0;
    while (halted !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    repeat (4) @(posedge clk);
    chk("halted", 32'h1, 32'(halted));
    chk("as_n", 32'h1, 32'(as_n));
    chk("data_oe", 32'h0, 32'(doe));
    chk("addr", 32'h0000a0, 32'(oaddr));
    chk("tsize", 32'(TSIZE_LONG), 32'(tsize));
    chk("cycles", 32'h1, log_q.size());
    halt_n <= 1'b1;
    wait_done();
    check_mem(24'h0000a0, 32'hcafe1234);
  endtask : halt_test

  task automatic auto_vector_ack_test();
    mute <= 1'b1;
    iack <= 1'b1;
    space <= SPACE_CPU;
    auto_vector_ack_n <= 1'b0;
    start(1'b1, TSIZE_BYTE, 24'h00000f, 32'h0);
    wait_done();
    chk("autovec", 32'h1, 32'(r_av));
    chk("rdata", 32'h0, r_data);
    chk("space", 32'(SPACE_CPU), 32'(ospace));
    extm <= 1'b1;
    repeat (3) @(posedge clk);
    chk("bus_oe", 32'h0, 32'(bus_oe));
    start(1'b1, TSIZE_BYTE, 24'h00000f, 32'h0);
    repeat (5) @(posedge clk);
    chk("busy", 32'h0, 32'(busy));
    extm <= 1'b0;
    mute <= 1'b0;
    iack <= 1'b0;
    space <= 3'h5;
    auto_vector_ack_n <= 1'b1;
    repeat (3) @(posedge clk);
    chk("bus_oe", 32'h1, 32'(bus_oe));
  endtask : auto_vector_ack_test

  task automatic close_out();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial begin
    {rst_n, req, iack, extm, mon_en, fault, mute} = 7'h00;
    {rd, halt_n, auto_vector_ack_n, wide} = 4'hf;
    sz = TSIZE_WORD;
    addr = 24'h000000;
    wdata = 32'h0;
    space = 3'h5;
    waits = 4'h0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("idle", 32'h7, {as_n, ds_n, oread});
    slow_read();
    long_read(1'b1, 24'h000030);
    long_read(1'b0, 24'h000020);
    byte_read(1'b1, 24'h000041);
    byte_read(1'b0, 24'h000043);
    long_write(1'b1, 24'h000080, 32'h11223344);
    long_write(1'b0, 24'h000090, 32'ha1b2c3d4);
    faults();
    halt_test();
    auto_vector_ack_test();
    close_out();
  end
endmodule : testbench
